// [fp_sign_exponent_convert_ops_tb.sv]
// Purpose: self-checking bench for the sign, exponent and integer-convert core
// Assumes: one request at a time, host model on the memory port
// Notes:   corner tables first, then random operations from a fixed seed
`timescale 1ns/1ps
module fp_sign_exponent_convert_ops_tb;
    logic                clk_sys = 1'b0;
    logic                srst = 1'b1;
    logic                req_valid = 1'b0;
    fsc_pkg::fsc_req_s   req = '0;
    logic [63:0]         mem_word = 64'h0;
    logic [1:0]          host_lat = 2'h0;
    logic                mem_rd_ack, mem_wr_ack, busy, done, mem_rd_req, mem_wr_req;
    logic                acc_we, exp_word_we, overflow_trap, underflow_trap, cc_we;
    logic [63:0]         mem_rd_data, mem_wr_data, acc_wdata;
    logic [15:0]         exp_word;
    fsc_pkg::fsc_flags_s flags;
    int                  fails = 0;
    int                  compares = 0;

    always #50 clk_sys = ~clk_sys;

    fsc_core fsc_core_i (.clk_sys, .srst, .req_valid, .req, .mem_rd_ack, .mem_rd_data, .mem_wr_ack, .busy, .done,
        .mem_rd_req, .mem_wr_req, .mem_wr_data, .acc_we, .acc_wdata, .exp_word, .exp_word_we, .overflow_trap,
        .underflow_trap, .flags, .cc_we);
    fsc_host_model fsc_host_model_i (.clk_sys, .srst, .mem_rd_req, .mem_wr_req, .mem_wr_data, .mem_word,
        .lat(host_lat), .mem_rd_ack, .mem_wr_ack, .mem_rd_data);

    // ======================================================
    // compare and closing
    // ======================================================
    task automatic chk_word(input string what, input logic [63:0] expv, input logic [63:0] got);
        compares++;
        if (got !== expv)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic expv, input logic got);
        chk_word(what, {63'h0, expv}, {63'h0, got});
    endtask

    task automatic conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ======================================================
    // expected integer convert result
    // ======================================================
    function automatic logic [63:0] cvt(input logic [31:0] src, input logic lg, input logic dp);
        logic [63:0] v;
        logic [7:0]  e;
        logic        sg;
        v = lg ? {src, 32'h0} : {src[15:0], 48'h0};
        e = lg ? 8'h9F : 8'h8F;
        sg = v[63];
        if (sg)
            v = -v;
        if (v == 64'h0)
            return 64'h0;
        for (int k = 0; k < 64 && !v[62]; k++)
        begin
            v = v << 1;
            e = e - 8'h01;
        end
        v = {sg, e, v[61:7]};
        return dp ? v : (v & 64'hFFFF_FFFF_0000_0000);
    endfunction

    // ======================================================
    // one operation: drive, watch every cycle, judge
    // ======================================================
    task automatic run_op(input fsc_pkg::fsc_op_e op, input logic mm, input logic lg, input logic dp,
                          input logic [63:0] acc, input logic [31:0] src, input logic [63:0] word, input int spam);
        logic [63:0] a_got, w_got, expv;
        logic [15:0] e_got, s;
        logic        a_seen, w_seen, e_seen, ov, uf, cc, rd_ok, bad_order, touched, legal;
        fsc_pkg::fsc_flags_s fl;
        int          n;
        {a_seen, w_seen, e_seen, ov, uf, cc, rd_ok, bad_order, touched} = '0;
        a_got = '0; w_got = '0; e_got = '0; fl = '0; n = 0;
        // the most negative integer has no normalized form within the starting exponent
        if (op == fsc_pkg::FSC_INT_CONVERT_OP && (lg ? src == 32'h8000_0000 : src[15:0] == 16'h8000)) src = 32'h1;
        @(posedge clk_sys);
        #1;
        mem_word = word;
        host_lat = 2'($urandom_range(0, 3));
        req = '{op: op, mem_mode: mm, long_int: lg, double_precision_select: dp, acc: acc, src: src};
        req_valid = 1'b1;
        do
        begin
            @(posedge clk_sys);
            #1;
            if (n >= spam) req_valid = 1'b0;
            else req.op = fsc_pkg::FSC_STORE_EXPONENT_OP;
            @(negedge clk_sys);
            n++;
            if (acc_we) {a_seen, a_got} = {1'b1, acc_wdata};
            if (exp_word_we) {e_seen, e_got} = {1'b1, exp_word};
            if (cc_we) {cc, fl} = {1'b1, flags};
            ov |= overflow_trap;
            uf |= underflow_trap;
            if (mem_wr_req && !rd_ok) bad_order = 1'b1;
            if (mem_rd_ack) rd_ok = 1'b1;
            if (mem_wr_ack) {w_seen, w_got} = {1'b1, mem_wr_data};
            if (mem_rd_req || mem_wr_req) touched = 1'b1;
        end
        while (done !== 1'b1 && n < 200);
        chk_bit("done", 1'b1, done);
        if (op != fsc_pkg::FSC_STORE_EXPONENT_OP) chk_bit("stray_store", 1'b0, e_seen);
        case (op)
            fsc_pkg::FSC_OP_ABS, fsc_pkg::FSC_OP_NEG:
            begin
                expv = mm ? word : acc;
                expv = (expv[62:55] == 8'h00) ? 64'h0 :
                       {(op == fsc_pkg::FSC_OP_NEG) ? ~expv[63] : 1'b0, expv[62:0]};
                if (mm)
                begin
                    chk_bit("wr_done", 1'b1, w_seen);
                    chk_word("wr_data", expv, w_got);
                    chk_bit("wr_before_rd", 1'b0, bad_order);
                end
                else
                begin
                    chk_bit("acc_we", 1'b1, a_seen);
                    chk_word("acc_wdata", expv, a_got);
                end
            end
            fsc_pkg::FSC_LOAD_EXPONENT_OP:
            begin
                s = mm ? src[15:0] : acc[63:48];
                legal = (s[15:7] == 9'h000 || s[15:7] == 9'h1FF) && s != 16'hFF80;
                chk_bit("overflow", !legal && !s[15], ov);
                chk_bit("underflow", !legal && s[15], uf);
                chk_bit("acc_we", legal, a_seen);
                if (legal) chk_word("acc_wdata", {acc[63], s[7:0] + 8'h80, acc[54:0]}, a_got);
            end
            fsc_pkg::FSC_INT_CONVERT_OP:
            begin
                chk_bit("acc_we", 1'b1, a_seen);
                chk_word("acc_wdata", cvt(src, lg, dp), a_got);
            end
            default:
            begin
                s = {{8{acc[62]}}, acc[62:55]} + 16'hFF80;
                s = {{8{s[7]}}, s[7:0]};
                chk_bit("exp_we", 1'b1, e_seen);
                chk_word("exp_word", {48'h0, s}, {48'h0, e_got});
                chk_bit("cc_we", 1'b1, cc);
                chk_word("flags", {60'h0, 2'b00, s == 16'h0, s[15]}, {60'h0, fl});
            end
        endcase
        if (!(mm && (op == fsc_pkg::FSC_OP_ABS || op == fsc_pkg::FSC_OP_NEG)))
            chk_bit("mem_touched", 1'b0, touched);
    endtask

    // ======================================================
    // main sequence
    // ======================================================
    initial
    begin
        logic [15:0] ldx [10] = '{16'h0000, 16'h007F, 16'hFF81, 16'hFFFF, 16'h0080, 16'h7FFF, 16'hFF80,
                                  16'hFF7F, 16'h8000, 16'h0100};
        logic [31:0] ints [7] = '{32'h0, 32'h1, 32'hFFFF_FFFF, 32'h7FFF, 32'h7FFF_FFFF, 32'hFFFF_FFFE, 32'h0123_4567};
        int seed;
        seed = $urandom(32'haba5);
        repeat (4) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        chk_bit("busy_reset", 1'b0, busy);
        for (int m = 0; m < 4; m++)
        begin
            run_op(fsc_pkg::fsc_op_e'(m % 2), m[1], 0, 0, 64'h8000_0000_0000_1234, 0, 64'h807F_FFFF_0000_0000, m);
            run_op(fsc_pkg::fsc_op_e'(m % 2), m[1], 0, 0, 64'hC0AB_0000_0000_0001, 0, 64'h4080_0000_0000_0003, 0);
        end
        foreach (ldx[i])
        begin
            run_op(fsc_pkg::FSC_LOAD_EXPONENT_OP, 1, 0, 0, 64'h8123_4567_89AB_CDEF, {16'h0, ldx[i]}, 0, i % 2);
            run_op(fsc_pkg::FSC_LOAD_EXPONENT_OP, 0, 0, 0, {ldx[i], 48'h5A5A_5A5A_5A5A}, 0, 0, 0);
        end
        foreach (ints[i])
            for (int m = 0; m < 4; m++)
                run_op(fsc_pkg::FSC_INT_CONVERT_OP, 1, m[1], m[0], 0, ints[i], 0, 0);
        for (int e = 0; e < 256; e++)
            run_op(fsc_pkg::FSC_STORE_EXPONENT_OP, e[0], 0, 0, {1'($urandom), e[7:0], 55'($urandom)}, 0, 0, 0);
        repeat (150)
            run_op(fsc_pkg::fsc_op_e'($urandom_range(0, 4)), 1'($urandom), 1'($urandom), 1'($urandom),
                   {$urandom, $urandom}, $urandom, {$urandom, $urandom}, 0);
        conclude();
    end

    initial
    begin
        #5_000_000;
        fails++;
        conclude();
    end
endmodule

// [fsc_core.sv]
// Purpose: abs, negate, load exponent, integer convert and store exponent datapath
// Assumes: host keeps mem_rd_data valid while mem_rd_ack is high
// Notes:   one request at a time; busy high until done pulses
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_core
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              req_valid,
    input  wire fsc_pkg::fsc_req_s req,
    input  wire logic              mem_rd_ack,
    input  wire logic [63:0]       mem_rd_data,
    input  wire logic              mem_wr_ack,
    output logic                   busy,
    output logic                   done,
    output logic                   mem_rd_req,
    output logic                   mem_wr_req,
    output logic [63:0]            mem_wr_data,
    output logic                   acc_we,
    output logic [63:0]            acc_wdata,
    output logic [15:0]            exp_word,
    output logic                   exp_word_we,
    output logic                   overflow_trap,
    output logic                   underflow_trap,
    output fsc_pkg::fsc_flags_s    flags,
    output logic                   cc_we
);
    // =========================================================
    // state
    // =========================================================
    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_NORM, ST_DONE} fsc_st_e;
    fsc_st_e             st_reg, st_next;
    fsc_pkg::fsc_req_s   rq_reg, rq_next;
    logic [63:0]         frac_reg, frac_next;
    logic [7:0]          exp_reg, exp_next;
    logic                sgn_reg, sgn_next;
    logic [5:0]          cnt_reg, cnt_next;
    logic                busy_reg, busy_next;
    logic                done_reg, done_next;
    logic                rd_reg, rd_next;
    logic                wr_reg, wr_next;
    logic [63:0]         wdat_reg, wdat_next;
    logic                awe_reg, awe_next;
    logic [63:0]         adat_reg, adat_next;
    logic [15:0]         ew_reg, ew_next;
    logic                ewe_reg, ewe_next;
    logic                ov_reg, ov_next;
    logic                uf_reg, uf_next;
    fsc_pkg::fsc_flags_s fl_reg, fl_next;
    logic                cc_reg, cc_next;
    logic [63:0]         ns_frac;
    logic [7:0]          ns_exp;
    logic                ns_done;

    fsc_norm_step u_norm
    (
        .frac_in  (frac_reg),
        .exp_in   (exp_reg),
        .frac_out (ns_frac),
        .exp_out  (ns_exp),
        .done     (ns_done)
    );

    // =========================================================
    // helpers
    // =========================================================
    function automatic logic [63:0] sign_fix(input logic [63:0] w, input logic neg);
        logic [63:0] r;
        r = w;
        r[`FSC_SIGN_BIT] = neg ? ~w[`FSC_SIGN_BIT] : 1'b0;
        if (w[`FSC_EXP_HI:`FSC_EXP_LO] == 8'h00)
        begin
            r = 64'h0;
        end
        return r;
    endfunction

    logic [15:0] exp_in_src;
    logic [15:0] exp_in_sum;
    logic        exp_in_legal;
    logic [63:0] conv_raw;
    logic [15:0] exp_out_val;
    always_comb
    begin
        exp_in_src   = rq_reg.mem_mode ? rq_reg.src[15:0] : rq_reg.acc[63:48];
        exp_in_sum   = exp_in_src + `FSC_BIAS16;
        exp_in_legal = ((exp_in_src[15:7] == 9'h000) || (exp_in_src[15:7] == 9'h1FF))
                       && (exp_in_src != `FSC_SPECIAL_UF);
        // place at 63..48 or 63..32, then ST_NORM shifts right one
        conv_raw = rq_reg.long_int ? {rq_reg.src[31:0], 32'h0}
                                   : {rq_reg.src[15:0], 48'h0};
        exp_out_val = {{8{rq_reg.acc[`FSC_EXP_HI] ^ 1'b1}},
                       rq_reg.acc[`FSC_EXP_HI:`FSC_EXP_LO] + `FSC_BIAS8};
    end

    // =========================================================
    // next state
    // =========================================================
    always_comb
    begin
        st_next   = st_reg;
        rq_next   = rq_reg;
        frac_next = frac_reg;
        exp_next  = exp_reg;
        sgn_next  = sgn_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        rd_next   = rd_reg;
        wr_next   = wr_reg;
        wdat_next = wdat_reg;
        awe_next  = 1'b0;
        adat_next = adat_reg;
        ew_next   = ew_reg;
        ewe_next  = 1'b0;
        ov_next   = 1'b0;
        uf_next   = 1'b0;
        fl_next   = fl_reg;
        cc_next   = 1'b0;
        unique case (st_reg)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    rq_next   = req;
                    busy_next = 1'b1;
                    st_next   = ST_DONE;
                    if ((req.op == fsc_pkg::FSC_OP_ABS) || (req.op == fsc_pkg::FSC_OP_NEG))
                    begin
                        if (req.mem_mode)
                        begin
                            rd_next = 1'b1;
                            st_next = ST_READ;
                        end
                    end
                    else if (req.op == fsc_pkg::FSC_INT_CONVERT_OP)
                    begin
                        st_next = ST_NORM;
                    end
                end
            end
            ST_READ:
            begin
                if (mem_rd_ack)
                begin
                    rd_next   = 1'b0;
                    // write-back only after the read has completed
                    wdat_next = sign_fix(mem_rd_data, rq_reg.op == fsc_pkg::FSC_OP_NEG);
                    wr_next   = 1'b1;
                    st_next   = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                if (mem_wr_ack)
                begin
                    wr_next = 1'b0;
                    st_next = ST_DONE;
                end
            end
            ST_NORM:
            begin
                if (cnt_reg == 6'h00)
                begin
                    frac_next = conv_raw;
                    sgn_next  = conv_raw[63];
                    if (conv_raw[63])
                    begin
                        frac_next = ~conv_raw + 64'h1;
                    end
                    frac_next = {1'b0, frac_next[63:1]};
                    exp_next  = rq_reg.long_int ? `FSC_EXP_LONG : `FSC_EXP_SHORT;
                    exp_next  = exp_next + 8'h01;
                    cnt_next  = 6'h01;
                end
                else if (ns_done || (frac_reg == 64'h0) || (cnt_reg == `FSC_NORM_MAX))
                begin
                    adat_next = {sgn_reg, exp_reg, frac_reg[61:7]};
                    if (frac_reg == 64'h0)
                    begin
                        adat_next = 64'h0;
                    end
                    else if (!rq_reg.double_precision_select)
                    begin
                        adat_next = adat_next & `FSC_SINGLE_MASK;
                    end
                    awe_next = 1'b1;
                    cnt_next = 6'h00;
                    st_next  = ST_DONE;
                end
                else
                begin
                    frac_next = ns_frac;
                    exp_next  = ns_exp;
                    cnt_next  = cnt_reg + 6'h01;
                end
            end
            ST_DONE:
            begin
                unique case (rq_reg.op)
                    fsc_pkg::FSC_OP_ABS, fsc_pkg::FSC_OP_NEG:
                    begin
                        if (!rq_reg.mem_mode)
                        begin
                            awe_next  = 1'b1;
                            adat_next = sign_fix(rq_reg.acc, rq_reg.op == fsc_pkg::FSC_OP_NEG);
                        end
                    end
                    fsc_pkg::FSC_LOAD_EXPONENT_OP:
                    begin
                        if (exp_in_legal)
                        begin
                            awe_next  = 1'b1;
                            adat_next = rq_reg.acc;
                            adat_next[`FSC_EXP_HI:`FSC_EXP_LO] = exp_in_sum[7:0];
                        end
                        else
                        begin
                            ov_next = ~exp_in_src[15];
                            uf_next = exp_in_src[15];
                        end
                    end
                    fsc_pkg::FSC_STORE_EXPONENT_OP:
                    begin
                        ew_next  = exp_out_val;
                        ewe_next = 1'b1;
                        fl_next.fp_carry_flag    = 1'b0;
                        fl_next.fp_overflow_flag = 1'b0;
                        fl_next.fp_zero_flag     = (exp_out_val == 16'h0000);
                        fl_next.fp_negative_flag = exp_out_val[15];
                        cc_next = 1'b1;
                    end
                    default:
                    begin
                    end
                endcase
                done_next = 1'b1;
                busy_next = 1'b0;
                st_next   = ST_IDLE;
            end
            default:
            begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_reg   <= ST_IDLE;
            rq_reg   <= '0;
            frac_reg <= 64'h0;
            exp_reg  <= 8'h00;
            sgn_reg  <= 1'b0;
            cnt_reg  <= 6'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rd_reg   <= 1'b0;
            wr_reg   <= 1'b0;
            wdat_reg <= 64'h0;
            awe_reg  <= 1'b0;
            adat_reg <= 64'h0;
            ew_reg   <= 16'h0000;
            ewe_reg  <= 1'b0;
            ov_reg   <= 1'b0;
            uf_reg   <= 1'b0;
            fl_reg   <= '0;
            cc_reg   <= 1'b0;
        end
        else
        begin
            st_reg   <= st_next;
            rq_reg   <= rq_next;
            frac_reg <= frac_next;
            exp_reg  <= exp_next;
            sgn_reg  <= sgn_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rd_reg   <= rd_next;
            wr_reg   <= wr_next;
            wdat_reg <= wdat_next;
            awe_reg  <= awe_next;
            adat_reg <= adat_next;
            ew_reg   <= ew_next;
            ewe_reg  <= ewe_next;
            ov_reg   <= ov_next;
            uf_reg   <= uf_next;
            fl_reg   <= fl_next;
            cc_reg   <= cc_next;
        end
    end

    assign busy           = busy_reg;
    assign done           = done_reg;
    assign mem_rd_req     = rd_reg;
    assign mem_wr_req     = wr_reg;
    assign mem_wr_data    = wdat_reg;
    assign acc_we         = awe_reg;
    assign acc_wdata      = adat_reg;
    assign exp_word       = ew_reg;
    assign exp_word_we    = ewe_reg;
    assign overflow_trap  = ov_reg;
    assign underflow_trap = uf_reg;
    assign flags          = fl_reg;
    assign cc_we          = cc_reg;

    // =========================================================
    // checks
    // =========================================================
    AST_NO_RW_OVERLAP: assert property (@(posedge clk_sys) disable iff (srst)
        !(rd_reg && wr_reg)) else $error("read and write overlap");
    AST_RW_ONLY_ABSNEG: assert property (@(posedge clk_sys) disable iff (srst)
        wr_reg |-> (rq_reg.op inside {fsc_pkg::FSC_OP_ABS, fsc_pkg::FSC_OP_NEG})) else $error("bad write");
    AST_READ_THEN_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(wr_reg) |-> $past(rd_reg)) else $error("write without read");
    AST_ABS_SIGN: assert property (@(posedge clk_sys) disable iff (srst)
        (acc_we && rq_reg.op == fsc_pkg::FSC_OP_ABS) |-> !acc_wdata[63]) else $error("abs sign");
    AST_STORE_EXP_FLAGS: assert property (@(posedge clk_sys) disable iff (srst)
        exp_word_we |-> (!flags.fp_carry_flag && !flags.fp_overflow_flag && cc_we
        && flags.fp_zero_flag == (exp_word == 16'h0000)
        && flags.fp_negative_flag == exp_word[15])) else $error("store exponent flags");
    AST_STORE_EXP_VALUE: assert property (@(posedge clk_sys) disable iff (srst)
        exp_word_we |-> (exp_word[7:0] == rq_reg.acc[62:55] - 8'h80
        && exp_word[15:8] == {8{exp_word[7]}})) else $error("store exponent value");
    AST_TRAP_EXCL: assert property (@(posedge clk_sys) disable iff (srst)
        !(overflow_trap && underflow_trap)) else $error("both traps");
    AST_NORM_BOUND: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg == ST_NORM) |-> ##[1:40] (st_reg == ST_DONE)) else $error("normalize hang");
    COV_ABS_MEM: cover property (@(posedge clk_sys) $fell(wr_reg));
    COV_EXP_UF: cover property (@(posedge clk_sys) underflow_trap);
    COV_CONV: cover property (@(posedge clk_sys) acc_we && rq_reg.op == fsc_pkg::FSC_INT_CONVERT_OP);
endmodule

// [fsc_host_model.sv]
// Purpose: host side model answering the core's memory read and write requests
// Assumes: one memory word held by the bench, acks pulse for one cycle
// Notes:   latency set per operation by the bench, 0 to 3 extra cycles
`timescale 1ns/1ps
module fsc_host_model
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        mem_rd_req,
    input  wire logic        mem_wr_req,
    input  wire logic [63:0] mem_wr_data,
    input  wire logic [63:0] mem_word,
    input  wire logic [1:0]  lat,
    output logic             mem_rd_ack,
    output logic             mem_wr_ack,
    output logic [63:0]      mem_rd_data
);
    logic [1:0] wait_cnt;

    // ======================================================
    // answer one request at a time
    // ======================================================
    always @(posedge clk_sys)
    begin
        mem_rd_ack  <= 1'b0;
        mem_wr_ack  <= 1'b0;
        // data outside an ack is the inverse, so a late sample never matches by chance
        mem_rd_data <= ~mem_word;
        if (srst)
            wait_cnt <= 2'h0;
        else if ((mem_rd_req || mem_wr_req) && !mem_rd_ack && !mem_wr_ack)
        begin
            if (wait_cnt >= lat)
            begin
                wait_cnt <= 2'h0;
                if (mem_rd_req)
                begin
                    mem_rd_ack  <= 1'b1;
                    mem_rd_data <= mem_word;
                end
                else
                    mem_wr_ack <= 1'b1;
            end
            else
                wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

// [fsc_map.svh]
// Purpose: constants for the sign, exponent and integer-convert datapath
// Assumes: 64-bit accumulator word, sign in bit 63, exponent in bits 62..55
// Notes:   octal figures written in hex
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
`define FSC_SIGN_BIT     63
`define FSC_EXP_HI       62
`define FSC_EXP_LO       55
`define FSC_BIAS8        8'h80
`define FSC_BIAS16       16'h0080
`define FSC_SPECIAL_UF   16'hFF80
`define FSC_EXP_SHORT    8'h8F
`define FSC_EXP_LONG     8'h9F
`define FSC_SINGLE_MASK  64'hFFFF_FFFF_0000_0000
`define FSC_NORM_MAX     6'h20
`endif

// [fsc_norm_step.sv]
// Purpose: one normalize step: shift left once and decrement the exponent
// Assumes: caller decides when to stop
// Notes:   none
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_norm_step
(
    input  wire logic [63:0] frac_in,
    input  wire logic [7:0]  exp_in,
    output logic      [63:0] frac_out,
    output logic      [7:0]  exp_out,
    output logic             done
);
    // normalized form: bit 63 zero, bit 62 one
    assign done     = (frac_in[63] == 1'b0) && frac_in[62];
    assign frac_out = {frac_in[62:0], 1'b0};
    assign exp_out  = exp_in - 8'h01;
endmodule

// [fsc_pkg.sv]
// Purpose: types for the sign, exponent and integer-convert datapath
// Assumes: nothing
// Notes:   none
package fsc_pkg;
    typedef enum logic [2:0] {FSC_OP_ABS, FSC_OP_NEG, FSC_LOAD_EXPONENT_OP, FSC_INT_CONVERT_OP,
                              FSC_STORE_EXPONENT_OP} fsc_op_e;
    typedef struct packed {
        fsc_op_e     op;
        logic        mem_mode;
        logic        long_int;
        logic        double_precision_select;
        logic [63:0] acc;
        logic [31:0] src;
    } fsc_req_s;
    typedef struct packed {
        logic fp_carry_flag;
        logic fp_overflow_flag;
        logic fp_zero_flag;
        logic fp_negative_flag;
    } fsc_flags_s;
endpackage
